// ---- src/cis_defines.svh ----
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH
// register byte offsets
`define CIS_INSTR_OFS 12'h000
`define CIS_CTRL_OFS 12'h004
`define CIS_WREG_OFS 12'h008
`define CIS_STATUS_OFS 12'h00C
`define CIS_OPTION_OFS 12'h010
`define CIS_IRQCTL_OFS 12'h014
`define CIS_PC_OFS 12'h018
`define CIS_STACK_OFS 12'h01C
`define CIS_WDOG_OFS 12'h020
`define CIS_FILE_BASE 3'h2
// field positions
`define CIS_TIMEOUT_BIT 4
`define CIS_POWERDOWN_BIT 3
`define CIS_ZERO_BIT 2
`define CIS_IRQEN_BIT 7
`define CIS_CTRL_WDEN_BIT 0
`define CIS_CTRL_UNK_BIT 1
`define CIS_CTRL_BUSY_BIT 2
// reset values
`define CIS_OPTION_RST 8'hFF
`define CIS_IRQCTL_RST 8'h00
`define CIS_PC_RST 13'h0000
// opcodes and masks
`define CIS_OP_WDCLR 14'h0064
`define CIS_OP_OPTION 14'h0062
`define CIS_OP_IRET 14'h0009
`define CIS_OP_RETURN 14'h0008
`define CIS_NOP_MASK 14'h3F9F
`define CIS_STORE_HI 7'h01
`define CIS_DEC_HI 6'h03
`define CIS_MOV_HI 6'h08
`define CIS_LITRET_HI 4'hD
`define CIS_STACK_DEPTH 8
`endif

// ---- src/cis_pkg.sv ----
`default_nettype none
package cis_pkg;
  typedef enum logic [3:0] {
    CIS_K_NOP,
    CIS_K_WDCLR,
    CIS_K_DEC,
    CIS_K_MOV,
    CIS_K_STORE,
    CIS_K_OPTION,
    CIS_K_IRET,
    CIS_K_LITRET,
    CIS_K_RETURN,
    CIS_K_UNKNOWN
  } cis_kind_t;
  typedef struct packed {
    logic timeout;
    logic powerdown;
    logic zero;
  } cis_status_t;
  typedef struct packed {
    cis_kind_t kind;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] literal;
  } cis_decode_t;
endpackage
`default_nettype wire

// ---- src/cis_core_exec.sv ----
// Function
// - watchdog clear zeroes the watchdog counter and its prescaler
// - watchdog clear sets the timeout and power-down flags
// - decrement file minus one, to w or file by dest, updates zero
// - move file copies file to w, or back to file, by dest
// - move file updates zero from the moved value
// - accumulator store writes w into file, flags untouched
// - interrupt return pops stack into program counter
// - interrupt return sets global interrupt enable, bit 7
// - literal return loads literal into w, pc from stack top
// - subroutine return pops stack into pc, flags untouched
// - each return takes two instruction cycles
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cis_defines.svh"
module cis_core_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic global_irq_enable,
  output logic [7:0] option_cfg
);
  logic [7:0] w;
  cis_pkg::cis_status_t status;
  logic [7:0] irq_control_reg;
  logic [12:0] pc;
  logic [12:0] stack [`CIS_STACK_DEPTH];
  logic [2:0] sp;
  logic [3:0] depth;
  logic [7:0] file_mem [128];
  logic [7:0] watchdog_counter;
  logic [7:0] wdog_prescale;
  logic wdog_en;
  logic unknown_seen;
  logic busy;
  logic [13:0] last_op;

  wire setup = psel && !penable;
  wire access = psel && penable;
  wire in_file = paddr[11:9] == `CIS_FILE_BASE;
  wire hit_instr = paddr == `CIS_INSTR_OFS;
  wire hit_ctrl = paddr == `CIS_CTRL_OFS;
  wire hit_wreg = paddr == `CIS_WREG_OFS;
  wire hit_status = paddr == `CIS_STATUS_OFS;
  wire hit_option = paddr == `CIS_OPTION_OFS;
  wire hit_irqctl = paddr == `CIS_IRQCTL_OFS;
  wire hit_pc = paddr == `CIS_PC_OFS;
  wire hit_stack = paddr == `CIS_STACK_OFS;
  wire hit_wdog = paddr == `CIS_WDOG_OFS;
  wire mapped = in_file || hit_instr || hit_ctrl || hit_wreg || hit_status
    || hit_option || hit_irqctl || hit_pc || hit_stack || hit_wdog;

  // issue stalls while the refetch cycle of a return is pending
  assign pready = !(access && pwrite && hit_instr && busy);
  assign pslverr = access && !mapped;
  wire wr_ok = access && pwrite && pready && mapped;
  wire exec = wr_ok && hit_instr;

  wire [13:0] op = pwdata[13:0];
  cis_pkg::cis_decode_t dec;
  assign dec.dest = op[7];
  assign dec.faddr = op[6:0];
  assign dec.literal = op[7:0];
  assign dec.kind =
    (op == `CIS_OP_WDCLR) ? cis_pkg::CIS_K_WDCLR :
    (op == `CIS_OP_OPTION) ? cis_pkg::CIS_K_OPTION :
    (op == `CIS_OP_IRET) ? cis_pkg::CIS_K_IRET :
    (op == `CIS_OP_RETURN) ? cis_pkg::CIS_K_RETURN :
    ((op & `CIS_NOP_MASK) == 14'h0000) ? cis_pkg::CIS_K_NOP :
    (op[13:7] == `CIS_STORE_HI) ? cis_pkg::CIS_K_STORE :
    (op[13:8] == `CIS_DEC_HI) ? cis_pkg::CIS_K_DEC :
    (op[13:8] == `CIS_MOV_HI) ? cis_pkg::CIS_K_MOV :
    (op[13:10] == `CIS_LITRET_HI) ? cis_pkg::CIS_K_LITRET :
    cis_pkg::CIS_K_UNKNOWN;

  wire do_wdclr = exec && dec.kind == cis_pkg::CIS_K_WDCLR;
  wire do_dec = exec && dec.kind == cis_pkg::CIS_K_DEC;
  wire do_mov = exec && dec.kind == cis_pkg::CIS_K_MOV;
  wire do_store = exec && dec.kind == cis_pkg::CIS_K_STORE;
  wire do_option = exec && dec.kind == cis_pkg::CIS_K_OPTION;
  wire do_iret = exec && dec.kind == cis_pkg::CIS_K_IRET;
  wire do_litret = exec && dec.kind == cis_pkg::CIS_K_LITRET;
  wire do_return = exec && dec.kind == cis_pkg::CIS_K_RETURN;
  wire do_nop = exec && dec.kind == cis_pkg::CIS_K_NOP;
  wire do_unknown = exec && dec.kind == cis_pkg::CIS_K_UNKNOWN;
  wire any_ret = do_iret || do_litret || do_return;

  wire [7:0] file_rd = file_mem[dec.faddr];
  wire [2:0] sp_top = sp - 3'd1;
  wire [12:0] stack_top = stack[sp_top];
  wire [7:0] dec_val = file_rd - 8'd1;
  wire [7:0] alu_val = do_dec ? dec_val : file_rd;
  wire alu_to_w = (do_dec || do_mov) && !dec.dest;
  wire alu_to_f = (do_dec || do_mov) && dec.dest;

  // program file: software window or executed instruction
  wire [6:0] sw_faddr = paddr[8:2];
  wire file_sw_wr = wr_ok && in_file;
  wire file_ex_wr = alu_to_f || do_store;
  wire [7:0] file_ex_val = do_store ? w : alu_val;
  always_ff @(posedge pclk)
  begin
    if (file_sw_wr)
      file_mem[sw_faddr] <= pwdata[7:0];
    else if (file_ex_wr)
      file_mem[dec.faddr] <= file_ex_val;
  end

  wire [7:0] next_w =
    alu_to_w ? alu_val :
    do_litret ? dec.literal :
    (wr_ok && hit_wreg) ? pwdata[7:0] : w;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      w <= 8'h00;
    else
      w <= next_w;
  end

  // watchdog: prescaler rolls into the counter, counter rollover is a timeout
  wire pre_wrap = wdog_en && (wdog_prescale == 8'hFF);
  wire wdog_wrap = pre_wrap && (watchdog_counter == 8'hFF);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_counter <= 8'h00;
      wdog_prescale <= 8'h00;
    end
    else if (do_wdclr)
    begin
      watchdog_counter <= 8'h00;
      wdog_prescale <= 8'h00;
    end
    else if (wdog_en)
    begin
      wdog_prescale <= wdog_prescale + 8'd1;
      if (pre_wrap)
        watchdog_counter <= watchdog_counter + 8'd1;
    end
  end

  wire zero_upd = do_dec || do_mov;
  cis_pkg::cis_status_t next_status;
  assign next_status.timeout = do_wdclr ? 1'b1 :
    wdog_wrap ? 1'b0 : status.timeout;
  assign next_status.powerdown = do_wdclr ? 1'b1 : status.powerdown;
  assign next_status.zero = zero_upd ? (alu_val == 8'h00) :
    (wr_ok && hit_status) ? pwdata[`CIS_ZERO_BIT] : status.zero;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= '{timeout: 1'b1, powerdown: 1'b1, zero: 1'b0};
    else
      status <= next_status;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      option_cfg <= `CIS_OPTION_RST;
    else if (do_option)
      option_cfg <= w;
    else if (wr_ok && hit_option)
      option_cfg <= pwdata[7:0];
  end

  wire [7:0] next_irqctl = (wr_ok && hit_irqctl) ? pwdata[7:0] : irq_control_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_control_reg <= `CIS_IRQCTL_RST;
    else if (do_iret)
      irq_control_reg <= irq_control_reg | 8'h80;
    else
      irq_control_reg <= next_irqctl;
  end
  assign global_irq_enable = irq_control_reg[`CIS_IRQEN_BIT];

  // return stack is circular, a pop of an empty stack wraps
  wire push = wr_ok && hit_stack;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp <= 3'd0;
      depth <= 4'd0;
    end
    else if (any_ret)
    begin
      sp <= sp_top;
      depth <= (depth == 4'd0) ? 4'd0 : depth - 4'd1;
    end
    else if (push)
    begin
      sp <= sp + 3'd1;
      depth <= (depth == 4'd8) ? 4'd8 : depth + 4'd1;
    end
  end
  always_ff @(posedge pclk)
  begin
    if (push && !any_ret)
      stack[sp] <= pwdata[12:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc <= `CIS_PC_RST;
    else if (any_ret)
      pc <= stack_top;
    else if (exec)
      pc <= pc + 13'd1;
    else if (wr_ok && hit_pc)
      pc <= pwdata[12:0];
  end

  // busy covers the refetch slot after a return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else
      busy <= any_ret;
  end

  wire unk_clr = wr_ok && hit_ctrl && pwdata[`CIS_CTRL_UNK_BIT];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdog_en <= 1'b0;
      unknown_seen <= 1'b0;
      last_op <= 14'h0000;
    end
    else
    begin
      if (wr_ok && hit_ctrl)
        wdog_en <= pwdata[`CIS_CTRL_WDEN_BIT];
      if (do_unknown)
        unknown_seen <= 1'b1;
      else if (unk_clr)
        unknown_seen <= 1'b0;
      if (exec)
        last_op <= op;
    end
  end

  wire [31:0] ctrl_rd = {29'h0, busy, unknown_seen, wdog_en};
  wire [31:0] status_rd = {27'h0, status.timeout, status.powerdown, status.zero, 2'b00};
  wire [31:0] next_rdata =
    in_file ? {24'h0, file_mem[sw_faddr]} :
    hit_instr ? {18'h0, last_op} :
    hit_ctrl ? ctrl_rd :
    hit_wreg ? {24'h0, w} :
    hit_status ? status_rd :
    hit_option ? {24'h0, option_cfg} :
    hit_irqctl ? {24'h0, irq_control_reg} :
    hit_pc ? {19'h0, pc} :
    hit_stack ? {28'h0, depth} :
    hit_wdog ? {16'h0, wdog_prescale, watchdog_counter} : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= next_rdata;
  end

  a_wdclr_counter: assert property (@(posedge pclk) disable iff (!presetn)
    do_wdclr |=> (watchdog_counter == 8'h00) && (wdog_prescale == 8'h00))
    else $error("watchdog clear left counter or prescaler nonzero");
  a_wdclr_flags: assert property (@(posedge pclk) disable iff (!presetn)
    do_wdclr |=> status.timeout && status.powerdown)
    else $error("watchdog clear did not set flags");
  a_dec_value: assert property (@(posedge pclk) disable iff (!presetn)
    (do_dec && !dec.dest) |=> (w == $past(file_rd) - 8'd1)
      && (status.zero == ($past(file_rd) == 8'h01)))
    else $error("decrement result or zero wrong");
  a_mov_to_w: assert property (@(posedge pclk) disable iff (!presetn)
    (do_mov && !dec.dest) |=> w == $past(file_rd))
    else $error("move file did not reach w");
  a_mov_zero: assert property (@(posedge pclk) disable iff (!presetn)
    do_mov |=> status.zero == ($past(file_rd) == 8'h00))
    else $error("move file zero flag wrong");
  a_store_flags: assert property (@(posedge pclk) disable iff (!presetn)
    do_store |=> $stable(status.zero) && $stable(status.powerdown))
    else $error("accumulator store touched flags");
  a_ret_pc_load: assert property (@(posedge pclk) disable iff (!presetn)
    (do_iret || do_return) |=> pc == $past(stack_top) && sp == $past(sp_top))
    else $error("return did not pop into pc");
  a_iret_enable: assert property (@(posedge pclk) disable iff (!presetn)
    do_iret |=> global_irq_enable)
    else $error("interrupt return left enable clear");
  a_litret_load: assert property (@(posedge pclk) disable iff (!presetn)
    do_litret |=> (w == $past(op[7:0])) && (pc == $past(stack_top)))
    else $error("literal return w or pc wrong");
  a_return_flags: assert property (@(posedge pclk) disable iff (!presetn)
    do_return |=> $stable(status.zero) && $stable(status.powerdown))
    else $error("subroutine return touched flags");
  a_ret_two_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    any_ret |=> busy ##1 !busy)
    else $error("return did not take two cycles");
  a_single_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && !any_ret) |=> !busy && (pc == $past(pc) + 13'd1))
    else $error("one cycle opcode stalled");
  a_option_load: assert property (@(posedge pclk) disable iff (!presetn)
    do_option |=> (option_cfg == $past(w)) && $stable(status.zero))
    else $error("option load wrong");
  // results written back to the file, literal return pop, quiet opcodes, and the unknown opcode flag
  a_dec_to_file: assert property (@(posedge pclk) disable iff (!presetn)
    (do_dec && dec.dest) |=> file_mem[$past(dec.faddr)] == $past(file_rd) - 8'd1)
    else $error("decrement did not reach the file");
  a_dec_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (do_dec && dec.dest) |=> status.zero == ($past(file_rd) == 8'h01))
    else $error("decrement to file zero flag wrong");
  a_mov_to_file: assert property (@(posedge pclk) disable iff (!presetn)
    (do_mov && dec.dest) |=> file_mem[$past(dec.faddr)] == $past(file_rd))
    else $error("move file changed the file");
  a_store_file: assert property (@(posedge pclk) disable iff (!presetn)
    do_store |=> file_mem[$past(dec.faddr)] == $past(w))
    else $error("accumulator store did not reach the file");
  a_litret_pop: assert property (@(posedge pclk) disable iff (!presetn)
    do_litret |=> sp == $past(sp_top))
    else $error("literal return did not pop");
  a_option_keep: assert property (@(posedge pclk) disable iff (!presetn)
    do_option |=> $stable(w) && $stable(status.powerdown))
    else $error("option load touched w or flags");
  a_nop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    do_nop |=> $stable(w) && $stable(status.zero) && $stable(option_cfg) && $stable(sp))
    else $error("no-op changed state");
  a_unknown_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    do_unknown |=> unknown_seen)
    else $error("unknown opcode not flagged");
endmodule
`default_nettype wire

// ---- bench/cis_prog_rom.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cis_defines.svh"
module cis_prog_rom (
  output logic [2:0][13:0] words
);
  // return sequence fetched by the bench, entry 0 first
  assign words = {`CIS_OP_RETURN, {`CIS_LITRET_HI, 2'b00, 8'hA5}, `CIS_OP_IRET};
endmodule
`default_nettype wire

// ---- bench/cis_core_exec_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cis_defines.svh"
module cis_core_exec_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic global_irq_enable;
  logic [7:0] option_cfg;
  logic [2:0][13:0] prog;
  int n_mismatch = 0;
  int comparisons = 0;
  always #25 pclk = ~pclk;
  cis_core_exec dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .global_irq_enable(global_irq_enable),
    .option_cfg(option_cfg)
  );
  cis_prog_rom rom_u (
    .words(prog)
  );
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // psel stays high: next setup follows at once, or idle drops it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      results();
    end
    penable <= 1'b0;
  endtask
  // gap with no transfer, lets outputs settle before a direct look
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
  endtask
  task automatic ex(input logic [13:0] op);
    wr(`CIS_INSTR_OFS, {18'h0_0000, op});
  endtask
  function automatic logic [11:0] fa(input logic [6:0] f);
    return 12'h400 | {3'h0, f, 2'b00};
  endfunction
  task automatic t_wdog();
    wr(`CIS_CTRL_OFS, 32'h0000_0001);
    idle(65540);
    wr(`CIS_CTRL_OFS, 32'h0000_0000);
    rd("status", `CIS_STATUS_OFS, 32'h0000_0008);
    wr(`CIS_STATUS_OFS, 32'h0000_0004);
    ex(`CIS_OP_WDCLR);
    rd("wdog", `CIS_WDOG_OFS, 32'h0000_0000);
    rd("status", `CIS_STATUS_OFS, 32'h0000_001C);
  endtask
  task automatic t_dec();
    wr(fa(7'd127), 32'h0000_0001);
    ex({`CIS_DEC_HI, 1'b1, 7'd127});
    rd("file", fa(7'd127), 32'h0000_0000);
    rd("status", `CIS_STATUS_OFS, 32'h0000_001C);
    ex({`CIS_DEC_HI, 1'b0, 7'd127});
    rd("w", `CIS_WREG_OFS, 32'h0000_00FF);
    rd("file", fa(7'd127), 32'h0000_0000);
    rd("status", `CIS_STATUS_OFS, 32'h0000_0018);
  endtask
  task automatic t_mov();
    ex({`CIS_MOV_HI, 1'b1, 7'd127});
    rd("status", `CIS_STATUS_OFS, 32'h0000_001C);
    rd("file", fa(7'd127), 32'h0000_0000);
    wr(fa(7'd0), 32'h0000_005A);
    ex({`CIS_MOV_HI, 1'b0, 7'd0});
    rd("w", `CIS_WREG_OFS, 32'h0000_005A);
    rd("status", `CIS_STATUS_OFS, 32'h0000_0018);
  endtask
  task automatic t_store();
    wr(`CIS_WREG_OFS, 32'h0000_0000);
    ex({`CIS_STORE_HI, 7'd3});
    rd("file", fa(7'd3), 32'h0000_0000);
    rd("status", `CIS_STATUS_OFS, 32'h0000_0018);
  endtask
  task automatic t_option();
    wr(`CIS_WREG_OFS, 32'h0000_004F);
    wr(`CIS_PC_OFS, 32'h0000_0010);
    ex(`CIS_OP_OPTION);
    idle(1);
    chk("option", {24'h00_0000, option_cfg}, 32'h0000_004F);
    ex(14'h0000);
    rd("pc", `CIS_PC_OFS, 32'h0000_0012);
    rd("w", `CIS_WREG_OFS, 32'h0000_004F);
    rd("ctrl", `CIS_CTRL_OFS, 32'h0000_0000);
  endtask
  task automatic t_ret();
    wr(`CIS_STACK_OFS, 32'h0000_0111);
    wr(`CIS_STACK_OFS, 32'h0000_0222);
    wr(`CIS_STACK_OFS, 32'h0000_0333);
    ex(prog[0]);
    rd("busy", `CIS_CTRL_OFS, 32'h0000_0004);
    rd("pc", `CIS_PC_OFS, 32'h0000_0333);
    chk("gie", {31'h0000_0000, global_irq_enable}, 32'h0000_0001);
    ex(prog[1]);
    rd("busy", `CIS_CTRL_OFS, 32'h0000_0004);
    rd("pc", `CIS_PC_OFS, 32'h0000_0222);
    rd("w", `CIS_WREG_OFS, 32'h0000_00A5);
    ex(prog[2]);
    rd("busy", `CIS_CTRL_OFS, 32'h0000_0004);
    rd("pc", `CIS_PC_OFS, 32'h0000_0111);
    rd("status", `CIS_STATUS_OFS, 32'h0000_0018);
    rd("depth", `CIS_STACK_OFS, 32'h0000_0000);
  endtask
  task automatic t_unk();
    logic [31:0] q;
    logic e;
    ex(14'h3FFF);
    rd("ctrl", `CIS_CTRL_OFS, 32'h0000_0002);
    wr(`CIS_CTRL_OFS, 32'h0000_0002);
    rd("ctrl", `CIS_CTRL_OFS, 32'h0000_0000);
    apb(1'b0, 12'h030, 32'h0000_0000, q, e);
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0001);
    chk("unmapped", q, 32'h0000_0000);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("option", {24'h00_0000, option_cfg}, 32'h0000_00FF);
    chk("gie", {31'h0000_0000, global_irq_enable}, 32'h0000_0000);
    t_wdog();
    t_dec();
    t_mov();
    t_store();
    t_option();
    t_ret();
    t_unk();
    results();
  end
endmodule
`default_nettype wire
